// ---- design/cpu_regs_pkg.sv ----
// package: constants, operation codes and carriers for the cpu register set
package cpu_regs_pkg;
    // condition flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_I = 3;
    localparam int FLAG_H = 4;
    localparam int FLAG_ONE_LO = 5;
    localparam int FLAG_ONE_HI = 6;
    localparam int FLAG_V = 7;
    // reset values
    localparam logic [15:0] STACK_PTR_RESET = 16'h00FF;
    localparam logic [7:0]  INDEX_HIGH_RESET = 8'h00;
    localparam logic [7:0]  STACK_LOW_RESET = 8'hFF;
    localparam logic [7:0]  FLAGS_RESET = 8'h68;
    localparam logic [7:0]  FLAGS_FIXED_ONES = 8'h60;
    // top-of-memory reset vector address
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
    // pointer constants
    localparam logic [15:0] PTR_ONE = 16'h0001;

    // single-byte operations on accumulator or low index byte
    typedef enum logic [3:0] {
        UOP_NONE, UOP_CLR, UOP_INC, UOP_DEC, UOP_COM, UOP_NEG,
        UOP_LSL, UOP_LSR, UOP_ASR, UOP_ROL, UOP_ROR
    } unary_op_type;

    // two-operand accumulator operations
    typedef enum logic [3:0] {
        AOP_NONE, AOP_ADD, AOP_ADC, AOP_SUB, AOP_SBC, AOP_AND, AOP_OR,
        AOP_XOR, AOP_LOAD, AOP_DAA
    } alu_op_type;

    // register-set command issued by the sequencer each cycle
    typedef struct packed {
        alu_op_type   alu_op;        // accumulator operation with operand
        unary_op_type acc_unary;     // unary op on accumulator
        unary_op_type idx_unary;     // unary op on low index byte
        logic         idx_load;      // load full index pair
        logic         idx_low_load;  // load low index byte
        logic         idx_post_inc;  // index pair plus one
        logic         sp_adjust;     // stack adjust by signed immediate
        logic         sp_low_reset;  // stack low byte reset
        logic         sp_load;       // load stack pointer
        logic         sp_push;       // stack pointer minus one
        logic         sp_pull;       // stack pointer plus one
        logic         pc_fetch;      // sequential fetch advance
        logic         pc_load;       // change of flow
        logic         mask_clear;    // clear interrupt mask
        logic         mask_set;      // set interrupt mask
        logic         flags_load;    // accumulator-to-flags or pulled flags
        logic         nz_test;       // set n,z from test value
        logic         nz_test16;     // test value is 16 bits wide
        logic         carry_write;   // carry from bit test branch
        logic         carry_value;   // carry value for carry_write
        logic         irq_push_done; // registers pushed in interrupt entry
        logic         instr_end;     // instruction boundary this cycle
    } reg_cmd_type;

    // operand data that arrives with a command
    typedef struct packed {
        logic [7:0]  operand;    // alu operand or loaded byte
        logic [15:0] word;       // 16-bit load or target address
        logic [7:0]  flags_in;   // value for flags_load
        logic [15:0] test_value; // value tested for n,z
    } reg_data_type;
endpackage

// ---- design/cpu_programmer_register_set.sv ----
// module: programmer-visible cpu registers and flag generation
`timescale 1ns/10ps
`default_nettype none

// Operation
// - accumulator 8 bits, reset leaves it alone
// - index pair high:low used as pointer
// - low index byte supports unary byte ops
// - reset clears index high, keeps low
// - 16-bit stack pointer to next free slot
// - stack adjust adds sign-extended immediate
// - reset loads stack pointer with 00FF
// - stack low reset changes low byte only
// - program counter advances on every fetch
// - jumps, branches, interrupts, returns load counter
// - leaving reset loads counter from top vector
// - flag bits six and five read one
// - overflow flag bit seven on signed overflow
// - half carry bit four on add nibble carry
// - decimal adjust corrects using half carry, carry
// - mask bit three blocks maskable interrupts
// - mask set after push, before handler
// - no interrupt right after mask clear
// - negative flag from result top bit
// - zero flag from all-zero result
// - carry flag from add carry, borrow, shifts
// - registers not in memory map, instructions only
// - interrupt push order counter low, high, index, acc, flags
module cpu_programmer_register_set (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        reset,
    // sequencer command and data
    input  wire cpu_regs_pkg::reg_cmd_type   cmd,
    input  wire cpu_regs_pkg::reg_data_type  data,
    input  wire logic                        irq_pending,
    input  wire logic                        vector_valid,
    input  wire logic [15:0]                 vector_word,
    // register views
    output logic [7:0]                       accum,
    output logic [15:0]                      index_pair,
    output logic [15:0]                      stack_ptr,
    output logic [15:0]                      prog_counter,
    output logic [7:0]                       condition_flags,
    // push byte stream for interrupt entry
    output logic [7:0]                       prog_counter_low,
    output logic [7:0]                       prog_counter_high,
    // interrupt gating and vector fetch
    output logic                             irq_take,
    output logic                             vector_req,
    output logic [15:0]                      vector_addr
);

    logic [7:0]  acc_r;
    logic [7:0]  idx_hi_r;
    logic [7:0]  idx_lo_r;
    logic [15:0] sp_r;
    logic [15:0] pc_r;
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [7:0]  acc_nxt;
    logic [7:0]  idx_lo_nxt;
    logic        irq_hold_r;
    logic        irq_take_r;
    logic        vec_wait_r;

    // unary byte operation: result[7:0], carry, overflow
    function automatic logic [9:0] unary(input cpu_regs_pkg::unary_op_type op,
                                         input logic [7:0] a, input logic c);
        logic [7:0] r;
        logic       co;
        logic       v;
        r = a;
        co = c;
        v = 1'b0;
        case (op)
            cpu_regs_pkg::UOP_CLR: begin
                r = 8'h00;
                co = c;
            end
            cpu_regs_pkg::UOP_INC: begin
                r = a + 8'h01;
                v = (a == 8'h7F);
            end
            cpu_regs_pkg::UOP_DEC: begin
                r = a - 8'h01;
                v = (a == 8'h80);
            end
            cpu_regs_pkg::UOP_COM: begin
                r = ~a;
                co = 1'b1;
            end
            cpu_regs_pkg::UOP_NEG: begin
                r = 8'h00 - a;
                co = (a != 8'h00);
                v = (a == 8'h80);
            end
            cpu_regs_pkg::UOP_LSL: begin
                r = {a[6:0], 1'b0};
                co = a[7];
                v = a[7] ^ a[6];
            end
            cpu_regs_pkg::UOP_LSR: begin
                r = {1'b0, a[7:1]};
                co = a[0];
                v = a[0];
            end
            cpu_regs_pkg::UOP_ASR: begin
                r = {a[7], a[7:1]};
                co = a[0];
                v = a[7] ^ a[0];
            end
            cpu_regs_pkg::UOP_ROL: begin
                r = {a[6:0], c};
                co = a[7];
                v = a[7] ^ a[6];
            end
            cpu_regs_pkg::UOP_ROR: begin
                r = {c, a[7:1]};
                co = a[0];
                v = c ^ a[0];
            end
            default: begin
                r = a;
            end
        endcase
        unary = {v, co, r};
    endfunction

    // sign extension of an 8-bit immediate to 16 bits
    function automatic logic [15:0] sext8(input logic [7:0] b);
        sext8 = {{8{b[7]}}, b};
    endfunction

    // accumulator and low index byte data path with flag generation
    always_comb begin
        logic [8:0]  sum;
        logic [4:0]  nib;
        logic [9:0]  ua;
        logic [9:0]  ux;
        logic [7:0]  corr;
        logic [8:0]  dsum;
        logic        cin;
        logic        res_ok;
        logic [7:0]  res;
        sum = 9'h000;
        nib = 5'h00;
        corr = 8'h00;
        dsum = 9'h000;
        cin = flags_r[cpu_regs_pkg::FLAG_C];
        res_ok = 1'b0;
        res = 8'h00;
        acc_nxt = acc_r;
        idx_lo_nxt = idx_lo_r;
        flags_nxt = flags_r;
        ua = unary(cmd.acc_unary, acc_r, cin);
        ux = unary(cmd.idx_unary, idx_lo_r, cin);
        case (cmd.alu_op)
            cpu_regs_pkg::AOP_ADD, cpu_regs_pkg::AOP_ADC: begin
                if (cmd.alu_op == cpu_regs_pkg::AOP_ADD) begin
                    cin = 1'b0;
                end
                sum = {1'b0, acc_r} + {1'b0, data.operand} + {8'h00, cin};
                nib = {1'b0, acc_r[3:0]} + {1'b0, data.operand[3:0]} + {4'h0, cin};
                acc_nxt = sum[7:0];
                flags_nxt[cpu_regs_pkg::FLAG_H] = nib[4];
                flags_nxt[cpu_regs_pkg::FLAG_C] = sum[8];
                flags_nxt[cpu_regs_pkg::FLAG_V] =
                    (acc_r[7] == data.operand[7]) && (sum[7] != acc_r[7]);
                res_ok = 1'b1;
            end
            cpu_regs_pkg::AOP_SUB, cpu_regs_pkg::AOP_SBC: begin
                if (cmd.alu_op == cpu_regs_pkg::AOP_SUB) begin
                    cin = 1'b0;
                end
                sum = {1'b0, acc_r} - {1'b0, data.operand} - {8'h00, cin};
                acc_nxt = sum[7:0];
                flags_nxt[cpu_regs_pkg::FLAG_C] = sum[8];
                flags_nxt[cpu_regs_pkg::FLAG_V] =
                    (acc_r[7] != data.operand[7]) && (sum[7] != acc_r[7]);
                res_ok = 1'b1;
            end
            cpu_regs_pkg::AOP_AND, cpu_regs_pkg::AOP_OR,
            cpu_regs_pkg::AOP_XOR, cpu_regs_pkg::AOP_LOAD: begin
                if (cmd.alu_op == cpu_regs_pkg::AOP_AND) begin
                    acc_nxt = acc_r & data.operand;
                end else if (cmd.alu_op == cpu_regs_pkg::AOP_OR) begin
                    acc_nxt = acc_r | data.operand;
                end else if (cmd.alu_op == cpu_regs_pkg::AOP_XOR) begin
                    acc_nxt = acc_r ^ data.operand;
                end else begin
                    acc_nxt = data.operand;
                end
                flags_nxt[cpu_regs_pkg::FLAG_V] = 1'b0;
                res_ok = 1'b1;
            end
            cpu_regs_pkg::AOP_DAA: begin
                // low digit and high digit corrections from h and c
                if (flags_r[cpu_regs_pkg::FLAG_H] || (acc_r[3:0] > 4'h9)) begin
                    corr[3:0] = 4'h6;
                end
                if (flags_r[cpu_regs_pkg::FLAG_C] || (acc_r > 8'h99)) begin
                    corr[7:4] = 4'h6;
                end
                dsum = {1'b0, acc_r} + {1'b0, corr};
                acc_nxt = dsum[7:0];
                flags_nxt[cpu_regs_pkg::FLAG_C] =
                    flags_r[cpu_regs_pkg::FLAG_C] | (corr[7:4] != 4'h0);
                res_ok = 1'b1;
            end
            default: begin
                if (cmd.acc_unary != cpu_regs_pkg::UOP_NONE) begin
                    acc_nxt = ua[7:0];
                    flags_nxt[cpu_regs_pkg::FLAG_C] = ua[8];
                    flags_nxt[cpu_regs_pkg::FLAG_V] = ua[9];
                    res_ok = 1'b1;
                end
            end
        endcase
        res = acc_nxt;
        if (cmd.idx_unary != cpu_regs_pkg::UOP_NONE) begin
            idx_lo_nxt = ux[7:0];
            flags_nxt[cpu_regs_pkg::FLAG_C] = ux[8];
            flags_nxt[cpu_regs_pkg::FLAG_V] = ux[9];
            res = ux[7:0];
            res_ok = 1'b1;
        end else if (cmd.idx_low_load) begin
            idx_lo_nxt = data.operand;
        end
        if (res_ok) begin
            flags_nxt[cpu_regs_pkg::FLAG_N] = res[7];
            flags_nxt[cpu_regs_pkg::FLAG_Z] = (res == 8'h00);
        end
        // loads and stores tested as 8 or 16 bits
        if (cmd.nz_test) begin
            if (cmd.nz_test16) begin
                flags_nxt[cpu_regs_pkg::FLAG_N] = data.test_value[15];
                flags_nxt[cpu_regs_pkg::FLAG_Z] = (data.test_value == 16'h0000);
            end else begin
                flags_nxt[cpu_regs_pkg::FLAG_N] = data.test_value[7];
                flags_nxt[cpu_regs_pkg::FLAG_Z] = (data.test_value[7:0] == 8'h00);
            end
            flags_nxt[cpu_regs_pkg::FLAG_V] = 1'b0;
        end
        if (cmd.carry_write) begin
            flags_nxt[cpu_regs_pkg::FLAG_C] = cmd.carry_value;
        end
        if (cmd.flags_load) begin
            flags_nxt = data.flags_in;
        end
        if (cmd.mask_clear) begin
            flags_nxt[cpu_regs_pkg::FLAG_I] = 1'b0;
        end
        if (cmd.mask_set || cmd.irq_push_done) begin
            flags_nxt[cpu_regs_pkg::FLAG_I] = 1'b1;
        end
        flags_nxt = flags_nxt | cpu_regs_pkg::FLAGS_FIXED_ONES;
    end

    // accumulator: no reset term at all
    always_ff @(posedge mclk) begin
        acc_r <= acc_nxt;
    end

    // low index byte keeps its value through reset
    always_ff @(posedge mclk) begin
        if (cmd.idx_load) begin
            idx_lo_r <= data.word[7:0];
        end else if (cmd.idx_post_inc) begin
            idx_lo_r <= idx_lo_r + 8'h01;
        end else begin
            idx_lo_r <= idx_lo_nxt;
        end
    end

    // high index byte cleared by reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            idx_hi_r <= cpu_regs_pkg::INDEX_HIGH_RESET;
        end else if (cmd.idx_load) begin
            idx_hi_r <= data.word[15:8];
        end else if (cmd.idx_post_inc && (idx_lo_r == 8'hFF)) begin
            idx_hi_r <= idx_hi_r + 8'h01;
        end
    end

    // stack pointer
    always_ff @(posedge mclk) begin
        if (reset) begin
            sp_r <= cpu_regs_pkg::STACK_PTR_RESET;
        end else if (cmd.sp_load) begin
            sp_r <= data.word;
        end else if (cmd.sp_adjust) begin
            sp_r <= sp_r + sext8(data.operand);
        end else if (cmd.sp_low_reset) begin
            sp_r <= {sp_r[15:8], cpu_regs_pkg::STACK_LOW_RESET};
        end else if (cmd.sp_push) begin
            sp_r <= sp_r - cpu_regs_pkg::PTR_ONE;
        end else if (cmd.sp_pull) begin
            sp_r <= sp_r + cpu_regs_pkg::PTR_ONE;
        end
    end

    // reset vector fetch request after release, then counter load
    always_ff @(posedge mclk) begin
        if (reset) begin
            vec_wait_r <= 1'b1;
        end else if (vector_valid) begin
            vec_wait_r <= 1'b0;
        end
    end

    // program counter
    always_ff @(posedge mclk) begin
        if (reset) begin
            pc_r <= 16'h0000;
        end else if (vec_wait_r) begin
            if (vector_valid) begin
                pc_r <= vector_word;
            end
        end else if (cmd.pc_load) begin
            pc_r <= data.word;
        end else if (cmd.pc_fetch) begin
            pc_r <= pc_r + cpu_regs_pkg::PTR_ONE;
        end
    end

    // flags register; mask set while in reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            flags_r <= cpu_regs_pkg::FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // interrupt acceptance at instruction boundaries
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_hold_r <= 1'b0;
            irq_take_r <= 1'b0;
        end else begin
            irq_take_r <= 1'b0;
            irq_hold_r <= !cmd.instr_end && (irq_hold_r || cmd.mask_clear ||
                (cmd.flags_load && !data.flags_in[cpu_regs_pkg::FLAG_I]));
            if (cmd.instr_end) begin
                irq_take_r <= irq_pending && !vec_wait_r &&
                    !flags_r[cpu_regs_pkg::FLAG_I] && !irq_hold_r;
            end
        end
    end

    // output registers; only reachable here, not memory mapped
    always_ff @(posedge mclk) begin
        if (reset) begin
            accum <= 8'h00;
            index_pair <= 16'h0000;
            stack_ptr <= 16'h0000;
            prog_counter <= 16'h0000;
            condition_flags <= cpu_regs_pkg::FLAGS_RESET;
            prog_counter_low <= 8'h00;
            prog_counter_high <= 8'h00;
            irq_take <= 1'b0;
            vector_req <= 1'b0;
            vector_addr <= cpu_regs_pkg::RESET_VECTOR_ADDR;
        end else begin
            accum <= acc_r;
            index_pair <= {idx_hi_r, idx_lo_r};
            stack_ptr <= sp_r;
            prog_counter <= pc_r;
            condition_flags <= flags_r | cpu_regs_pkg::FLAGS_FIXED_ONES;
            prog_counter_low <= pc_r[7:0];
            prog_counter_high <= pc_r[15:8];
            irq_take <= irq_take_r;
            vector_req <= vec_wait_r && !vector_valid;
            vector_addr <= cpu_regs_pkg::RESET_VECTOR_ADDR;
        end
    end

endmodule

`default_nettype wire

// ---- verif/cpu_regs_chk.sv ----
// checker: port relations of the cpu programmer register set
`timescale 1ns/10ps
`default_nettype none
module cpu_regs_chk (
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       reset,
    // sequencer side
    input wire cpu_regs_pkg::reg_cmd_type  cmd,
    input wire cpu_regs_pkg::reg_data_type data,
    input wire logic                       irq_pending,
    input wire logic                       vector_valid,
    input wire logic [15:0]                vector_word,
    // register views
    input wire logic [15:0]                index_pair,
    input wire logic [15:0]                stack_ptr,
    input wire logic [15:0]                prog_counter,
    input wire logic [7:0]                 condition_flags,
    input wire logic                       irq_take,
    input wire logic                       vector_req,
    input wire logic [15:0]                vector_addr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // reset released with an idle sequencer
    sequence release_seq;
        $fell(reset) && cmd == '0;
    endsequence
    // counter commands are live only once the vector is in and reset is two edges gone
    sequence pc_ready_seq;
        !vector_req && !$past(reset) && !$past(reset, 2);
    endsequence
    // mask cleared without a boundary, boundary on the next cycle
    sequence clear_then_end_seq;
        cmd.mask_clear && !cmd.mask_set && !cmd.flags_load && !cmd.instr_end ##1 cmd.instr_end;
    endsequence
    AST_RESET_SP: assert property (release_seq |-> ##2 stack_ptr == 16'h00FF)
        else $error("stack pointer not 00FF after reset");
    AST_RESET_INDEX: assert property (release_seq |-> ##2 index_pair[15:8] == 8'h00)
        else $error("index high byte not cleared by reset");
    AST_RESET_MASK: assert property (release_seq |-> ##2 condition_flags[3])
        else $error("interrupt mask not set by reset");
    AST_FLAG_ONES: assert property (condition_flags[6:5] == 2'b11)
        else $error("fixed flag bits not one");
    AST_VECTOR_ADDR: assert property (vector_addr == 16'hFFFE)
        else $error("vector address wrong");
    AST_PC_VECTOR: assert property (vector_req && vector_valid |-> ##2
        prog_counter == $past(vector_word, 2)) else $error("counter not loaded from vector");
    AST_PC_FETCH: assert property (pc_ready_seq ##0 (cmd.pc_fetch && !cmd.pc_load) |->
        ##2 prog_counter == $past(prog_counter) + 16'h0001) else $error("fetch did not advance");
    AST_PC_LOAD: assert property (pc_ready_seq ##0 cmd.pc_load |->
        ##2 prog_counter == $past(data.word, 2)) else $error("change of flow target wrong");
    AST_SP_LOW_RESET: assert property (cmd.sp_low_reset && !cmd.sp_load && !cmd.sp_adjust |->
        ##2 stack_ptr[7:0] == 8'hFF && stack_ptr[15:8] == $past(stack_ptr[15:8]))
        else $error("stack low reset wrong");
    AST_IDX_UNARY_HIGH: assert property (cmd.idx_unary != cpu_regs_pkg::UOP_NONE &&
        !cmd.idx_load && !cmd.idx_post_inc |-> ##2 index_pair[15:8] == $past(index_pair[15:8]))
        else $error("low byte operation touched high byte");
    AST_IRQ_MASKED: assert property (cmd.instr_end ##1 condition_flags[3] |-> ##1 !irq_take)
        else $error("interrupt taken while masked");
    AST_IRQ_CAUSE: assert property (irq_take |-> $past(cmd.instr_end, 2) && $past(irq_pending, 2))
        else $error("interrupt taken without boundary and request");
    AST_IRQ_AFTER_CLEAR: assert property (clear_then_end_seq |-> ##2 !irq_take)
        else $error("interrupt taken right after mask clear");
    AST_MASK_AFTER_PUSH: assert property (cmd.irq_push_done && !cmd.flags_load |->
        ##2 condition_flags[3]) else $error("mask not set after push");
endmodule
bind cpu_programmer_register_set cpu_regs_chk chk (.mclk(mclk), .reset(reset), .cmd(cmd),
    .data(data), .irq_pending(irq_pending), .vector_valid(vector_valid),
    .vector_word(vector_word), .index_pair(index_pair), .stack_ptr(stack_ptr),
    .prog_counter(prog_counter), .condition_flags(condition_flags), .irq_take(irq_take),
    .vector_req(vector_req), .vector_addr(vector_addr));
`default_nettype wire

// ---- verif/cpu_programmer_register_set_test.sv ----
// testbench: directed scenarios for the cpu programmer register set
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %0h, expected %0h", $time, got, exp); end end
module cpu_programmer_register_set_test;
    // design connections
    logic                       mclk;
    logic                       reset;
    cpu_regs_pkg::reg_cmd_type  cmd;
    cpu_regs_pkg::reg_data_type data;
    logic                       irq_pending;
    logic                       vector_valid;
    logic [15:0]                vector_word;
    logic [7:0]                 accum;
    logic [15:0]                index_pair;
    logic [15:0]                stack_ptr;
    logic [15:0]                prog_counter;
    logic [7:0]                 condition_flags;
    logic [7:0]                 pc_low;
    logic [7:0]                 pc_high;
    logic                       irq_take;
    logic                       vector_req;
    logic [15:0]                vector_addr;
    // bookkeeping and tables: low byte after each unary op CLR through ASR on 81, add cases {a, b, sum, flags}
    int                         failures;
    int                         check_count;
    int                         cycles;
    cpu_regs_pkg::reg_cmd_type  c;
    logic [7:0]                 ures [8] = '{8'h00, 8'h82, 8'h80, 8'h7E, 8'h7F, 8'h02, 8'h40, 8'hC0};
    logic [31:0]                adds [4] = '{32'h0808_1078, 32'h7F01_80FC, 32'hFF01_007B, 32'h8080_00EB};

    cpu_programmer_register_set dut (.mclk(mclk), .reset(reset), .cmd(cmd), .data(data),
        .irq_pending(irq_pending), .vector_valid(vector_valid), .vector_word(vector_word),
        .accum(accum), .index_pair(index_pair), .stack_ptr(stack_ptr),
        .prog_counter(prog_counter), .condition_flags(condition_flags),
        .prog_counter_low(pc_low), .prog_counter_high(pc_high), .irq_take(irq_take),
        .vector_req(vector_req), .vector_addr(vector_addr));

    // clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one command cycle then an idle cycle, so the outputs show the result on return
    task automatic op(input cpu_regs_pkg::reg_cmd_type k, input logic [15:0] w);
        cmd = k;
        data = {w[7:0], w, w[7:0], w};
        @(negedge mclk);
        cmd = '0;
        @(negedge mclk);
    endtask

    // release reset and hand in the vector
    task automatic start_run(input logic [15:0] vec);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK(vector_req, 1'b1)
        `CHK(stack_ptr, 16'h00FF)
        `CHK(condition_flags, 8'h68)
        vector_word = vec;
        vector_valid = 1'b1;
        @(negedge mclk);
        vector_valid = 1'b0;
        @(negedge mclk);
        `CHK(prog_counter, vec)
        `CHK(vector_req, 1'b0)
    endtask

    task automatic test_counter();
        c = '0;
        c.pc_fetch = 1'b1;
        repeat (3) op(c, 16'h0000);
        `CHK(prog_counter, 16'hC003)
        c = '0;
        c.pc_load = 1'b1;
        op(c, 16'h8123);
        `CHK(prog_counter, 16'h8123)
        `CHK({pc_high, pc_low}, 16'h8123)
    endtask

    task automatic test_stack();
        c = '0;
        c.sp_adjust = 1'b1;
        op(c, 16'h00F0);
        `CHK(stack_ptr, 16'h00EF)
        op(c, 16'h0011);
        `CHK(stack_ptr, 16'h0100)
        c = '0;
        c.sp_load = 1'b1;
        op(c, 16'h1234);
        c = '0;
        c.sp_low_reset = 1'b1;
        op(c, 16'h0000);
        `CHK(stack_ptr, 16'h12FF)
        c = '0;
        c.sp_push = 1'b1;
        op(c, 16'h0000);
        `CHK(stack_ptr, 16'h12FE)
        c = '0;
        c.sp_pull = 1'b1;
        op(c, 16'h0000);
        `CHK(stack_ptr, 16'h12FF)
    endtask

    task automatic test_index();
        c = '0;
        c.idx_load = 1'b1;
        op(c, 16'h12FF);
        c = '0;
        c.idx_post_inc = 1'b1;
        op(c, 16'h0000);
        `CHK(index_pair, 16'h1300)
        for (int i = 0; i < 8; i++) begin
            c = '0;
            c.idx_low_load = 1'b1;
            op(c, 16'h0081);
            c = '0;
            c.idx_unary = cpu_regs_pkg::unary_op_type'(i + 1);
            op(c, 16'h0000);
            `CHK(index_pair, {8'h13, ures[i]})
        end
    endtask

    // load then one arithmetic step on the accumulator
    task automatic acc_pair(input logic [7:0] a, input cpu_regs_pkg::alu_op_type k,
                            input logic [7:0] b);
        c = '0;
        c.alu_op = cpu_regs_pkg::AOP_LOAD;
        op(c, {8'h00, a});
        c.alu_op = k;
        op(c, {8'h00, b});
    endtask

    task automatic test_flags();
        for (int i = 0; i < 4; i++) begin
            acc_pair(adds[i][31:24], cpu_regs_pkg::AOP_ADD, adds[i][23:16]);
            `CHK(accum, adds[i][15:8])
            `CHK(condition_flags, adds[i][7:0])
        end
        acc_pair(8'h00, cpu_regs_pkg::AOP_SUB, 8'h01);
        `CHK(condition_flags & 8'hEF, 8'h6D)
        acc_pair(8'h09, cpu_regs_pkg::AOP_ADC, 8'h08);
        c = '0;
        c.alu_op = cpu_regs_pkg::AOP_DAA;
        op(c, 16'h0000);
        `CHK(accum, 8'h18)
    endtask

    task automatic test_interrupts();
        irq_pending = 1'b1;
        c = '0;
        c.instr_end = 1'b1;
        op(c, 16'h0000);
        `CHK(irq_take, 1'b0)
        c = '0;
        c.mask_clear = 1'b1;
        cmd = c;
        @(negedge mclk);
        c = '0;
        c.instr_end = 1'b1;
        op(c, 16'h0000);
        `CHK(irq_take, 1'b0)
        op(c, 16'h0000);
        `CHK(irq_take, 1'b1)
        @(negedge mclk);
        `CHK(irq_take, 1'b0)
        c = '0;
        c.irq_push_done = 1'b1;
        op(c, 16'h0000);
        `CHK(condition_flags[3], 1'b1)
        c = '0;
        c.flags_load = 1'b1;
        op(c, 16'h0000);
        `CHK(condition_flags, 8'h60)
        c = '0;
        c.instr_end = 1'b1;
        op(c, 16'h0000);
        `CHK(irq_take, 1'b0)
        irq_pending = 1'b0;
    endtask

    // accumulator and low index byte survive a second reset
    task automatic test_reset_keep();
        c = '0;
        c.alu_op = cpu_regs_pkg::AOP_LOAD;
        op(c, 16'h005A);
        c = '0;
        c.idx_load = 1'b1;
        op(c, 16'h1234);
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        start_run(16'h8000);
        `CHK(accum, 8'h5A)
        `CHK(index_pair, 16'h0034)
    endtask

    // main sequence
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        cmd = '0;
        data = '0;
        irq_pending = 1'b0;
        vector_valid = 1'b0;
        vector_word = 16'h0000;
        failures = 0;
        check_count = 0;
        cycles = 0;
        repeat (8) @(negedge mclk);
        `CHK(condition_flags, 8'h68)
        start_run(16'hC000);
        test_counter();
        test_stack();
        test_index();
        test_flags();
        test_interrupts();
        test_reset_keep();
        stop_test();
    end
endmodule
`default_nettype wire
